/* pkg/osf_params.svh */
`ifndef OSF_PARAMS_SVH
`define OSF_PARAMS_SVH

// Register byte offsets
`define OSF_ADDR_CTRL    5'h00
`define OSF_ADDR_FSEL0   5'h04
`define OSF_ADDR_FSEL1   5'h08
`define OSF_ADDR_FSEL2   5'h0C
`define OSF_ADDR_STATUS  5'h10
`define OSF_ADDR_DECEL   5'h14

// Control word fields
`define OSF_CTRL_POL_LSB 0
`define OSF_CTRL_OPM_LSB 4
`define OSF_CTRL_NET_BIT 8
`define OSF_CTRL_RUN_BIT 9

// Reset values
`define OSF_POL_RST      3'h0
`define OSF_OPM_RST      4'h0
`define OSF_DECEL_RST    16'h0064
`define OSF_FSEL_RST     96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF

// Terminal function codes and selector values
`define OSF_FUNC_STOP    8'h18
`define OSF_FUNC_LOCK    8'h19
`define OSF_OPM_LOCK     4'h7
`define OSF_TERMS        12

// Response bound on the stop request
`define OSF_RESP_MAX_NS  2000000
`define OSF_CLK_NS       10
`define OSF_RESP_CYC     (`OSF_RESP_MAX_NS / `OSF_CLK_NS)

`endif

/* pkg/osf_pkg.sv */
package osf_pkg;
	typedef enum logic [1:0] {
		OSF_IDLE  = 2'h0,
		OSF_RUN   = 2'h1,
		OSF_DECEL = 2'h3
	} osf_state_e;
	typedef logic [2:0]  osf_pol_t;
	typedef logic [3:0]  osf_opm_t;
	typedef logic [7:0]  osf_code_t;
	typedef logic [95:0] osf_fsel_t;
endpackage

/* pkg/osf_dec_if.sv */
`timescale 1ns/1ps
interface osf_dec_if;
	import osf_pkg::*;
	logic [11:0] term_in;
	osf_fsel_t   fsel;
	logic        ext_in;
	logic        ext_asg;
	logic        lock_in;
	logic        lock_asg;
	logic        net_in;
	osf_pol_t    pol;
	osf_opm_t    opm;
	logic        permit;
	logic        panel_lock;
	logic        term_stop;
	modport top (output term_in, fsel, net_in, pol, opm,
		input permit, panel_lock, term_stop, ext_in, ext_asg, lock_in, lock_asg);
	modport map (input term_in, fsel, output ext_in, ext_asg, lock_in, lock_asg);
	modport dec (input ext_in, ext_asg, lock_in, lock_asg, net_in, pol, opm,
		output permit, panel_lock, term_stop);
endinterface

/* logic/osf_term_map.sv */
`timescale 1ns/1ps
`include "osf_params.svh"
module osf_term_map (
	osf_dec_if.map m     // Terminal routing side
);
	import osf_pkg::*;

	// Collect terminals whose function code matches and whether any does
	function automatic logic [1:0] gather(input osf_fsel_t sel, input logic [11:0] t,
		input osf_code_t code);
		logic on;
		logic asg;
		on = 1'b0;
		asg = 1'b0;
		for (int i = 0; i < `OSF_TERMS; i++) begin
			if (sel[8*i +: 8] == code) begin
				asg = 1'b1;
				on = on | t[i];
			end
		end
		return {asg, on};
	endfunction

	// Only code 24 routes a terminal to the stop request
	always_comb begin
		{m.ext_asg, m.ext_in}   = gather(m.fsel, m.term_in, `OSF_FUNC_STOP);
		{m.lock_asg, m.lock_in} = gather(m.fsel, m.term_in, `OSF_FUNC_LOCK);
	end
endmodule // osf_term_map

/* logic/osf_decide.sv */
`timescale 1ns/1ps
`include "osf_params.svh"
module osf_decide (
	osf_dec_if.dec d     // Decision side
);
	import osf_pkg::*;

	logic nc;
	logic split;
	logic as_lock;
	logic net_stop;

	// Polarity decode, terminal stop level and permit
	always_comb begin
		nc      = (d.pol >= 3'h2) && (d.pol <= 3'h5);
		split   = (d.pol == 3'h4) || (d.pol == 3'h5);
		as_lock = (d.opm == `OSF_OPM_LOCK) && d.ext_asg && !d.lock_asg;
		d.term_stop = d.ext_asg && (nc ? !d.ext_in : d.ext_in);
		net_stop = (nc && !split) ? !d.net_in : d.net_in;
		d.permit = !((d.term_stop && !as_lock) || net_stop);
		// Panel lock from the stop input or from its own terminal
		d.panel_lock = 1'b0;
		if (d.opm == `OSF_OPM_LOCK) begin
			d.panel_lock = as_lock ? d.term_stop : (d.lock_asg && d.lock_in);
		end
	end
endmodule // osf_decide

/* logic/osf_top.sv */
// Function
// - Stop request cuts drive output immediately
// - Terminal routes to stop only with code 24
// - React to stop change within 2 ms
// - While stopped, ignore run, motor stays undriven
// - Run removal decelerates; stop makes motor coast
// - Selection 2 or 3: stop input normally closed
// - Selection 4/5: terminal closed, network open
// - Mode 7 without lock terminal: stop acts lock
// - Mode 7, selection 0/1, both assigned: split
// - Mode 7, selection 2-5: closed lock or shutoff
// - Terminal stop shuts off in every mode except mode 7 without lock terminal
// - Polarity selection resets to 0
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "osf_params.svh"
module osf_top #(
	parameter int unsigned RESP_MAX_CYC = `OSF_RESP_CYC  // Stop response bound in cycles
) (
	input  wire logic        clk_i,             // 100 MHz clock
	input  wire logic        sys_rst_i,         // Synchronous reset, active high
	input  wire logic [11:0] term_i,            // Physical input terminals
	input  wire logic [4:0]  avs_address_i,     // Byte address
	input  wire logic        avs_read_i,        // Read request
	input  wire logic        avs_write_i,       // Write request
	input  wire logic [31:0] avs_writedata_i,   // Write data
	input  wire logic [3:0]  avs_byteenable_i,  // Byte lanes
	output logic [31:0]      avs_readdata_o,    // Read data
	output logic             avs_waitrequest_o, // Wait request
	output logic             drive_en_o,        // Output stage enabled
	output logic             decel_o,           // Decelerating to stop
	output logic             coast_o,           // Output released, coasting
	output logic             panel_lock_o,      // Operator panel locked
	output logic             stop_active_o,     // Stop request in force
	output osf_pkg::osf_pol_t pol_o             // Current polarity selection
);
	import osf_pkg::*;

	typedef struct packed {
		logic        wait_r;
		logic [31:0] rdata;
		osf_pol_t    pol;
		osf_opm_t    opm;
		logic        net;
		logic        run;
		osf_fsel_t   fsel;
		logic [15:0] decel_time;
		logic [15:0] decel_cnt;
		osf_state_e  state;
		logic        drive;
		logic        decel;
		logic        coast;
		logic        lock;
		logic        stop;
	} osf_top_s;

	osf_top_s s_q;
	osf_top_s s_d;

	osf_dec_if dif ();

	logic        req;
	logic        acc;
	logic [31:0] ctrl_w;
	logic [31:0] stat_w;
	logic [31:0] ctrl_m;
	logic [31:0] decel_m;

	// Merge write data into a word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Routing and decision submodules
	osf_term_map u_map (
		.m (dif.map)
	);
	osf_decide u_dec (
		.d (dif.dec)
	);

	// Drive the shared decision inputs
	assign dif.term_in = term_i;
	assign dif.fsel    = s_q.fsel;
	assign dif.net_in  = s_q.net;
	assign dif.pol     = s_q.pol;
	assign dif.opm     = s_q.opm;

	// Register views
	assign ctrl_w = {22'h00_0000, s_q.run, s_q.net, s_q.opm, 1'b0, s_q.pol};
	assign stat_w = {26'h000_0000, s_q.state, s_q.stop, s_q.lock, s_q.decel, s_q.drive};
	assign req    = avs_read_i | avs_write_i;
	assign acc    = req && !s_q.wait_r;

	// Write data merged under byte enables, one copy per target word
	assign ctrl_m  = be_merge(ctrl_w, avs_writedata_i, avs_byteenable_i);
	assign decel_m = be_merge({16'h0000, s_q.decel_time}, avs_writedata_i, avs_byteenable_i);

	// Next state: bus slave, settings and run control
	always_comb begin
		s_d = s_q;
		// One wait cycle, then the access completes
		s_d.wait_r = !(req && s_q.wait_r);
		if (req && s_q.wait_r) begin
			unique case (avs_address_i)
				`OSF_ADDR_CTRL:   s_d.rdata = ctrl_w;
				`OSF_ADDR_FSEL0:  s_d.rdata = s_q.fsel[31:0];
				`OSF_ADDR_FSEL1:  s_d.rdata = s_q.fsel[63:32];
				`OSF_ADDR_FSEL2:  s_d.rdata = s_q.fsel[95:64];
				`OSF_ADDR_STATUS: s_d.rdata = stat_w;
				`OSF_ADDR_DECEL:  s_d.rdata = {16'h0000, s_q.decel_time};
				default:          s_d.rdata = 32'h0000_0000;
			endcase
		end
		// Writes take effect on the completing edge
		if (acc && avs_write_i) begin
			unique case (avs_address_i)
				`OSF_ADDR_CTRL: begin
					s_d.pol = ctrl_m[2:0];
					s_d.opm = ctrl_m[7:4];
					s_d.net = ctrl_m[`OSF_CTRL_NET_BIT];
					s_d.run = ctrl_m[`OSF_CTRL_RUN_BIT];
				end
				`OSF_ADDR_FSEL0: s_d.fsel[31:0]  =
					be_merge(s_q.fsel[31:0], avs_writedata_i, avs_byteenable_i);
				`OSF_ADDR_FSEL1: s_d.fsel[63:32] =
					be_merge(s_q.fsel[63:32], avs_writedata_i, avs_byteenable_i);
				`OSF_ADDR_FSEL2: s_d.fsel[95:64] =
					be_merge(s_q.fsel[95:64], avs_writedata_i, avs_byteenable_i);
				`OSF_ADDR_DECEL: s_d.decel_time = decel_m[15:0];
				default: ;
			endcase
		end
		// Run state machine; stop decided combinationally for a one-cycle response
		unique case (s_q.state)
			OSF_IDLE: begin
				if (s_q.run && dif.permit) begin
					s_d.state = OSF_RUN;
					s_d.coast = 1'b0;
				end
			end
			OSF_RUN: begin
				if (!dif.permit) begin
					s_d.state = OSF_IDLE;
					s_d.coast = 1'b1;
				end else if (!s_q.run) begin
					s_d.state     = OSF_DECEL;
					s_d.decel_cnt = s_q.decel_time;
				end
			end
			OSF_DECEL: begin
				if (!dif.permit) begin
					s_d.state = OSF_IDLE;
					s_d.coast = 1'b1;
				end else if (s_q.run) begin
					s_d.state = OSF_RUN;
				end else if (s_q.decel_cnt == 16'h0000) begin
					s_d.state = OSF_IDLE;
				end else begin
					s_d.decel_cnt = s_q.decel_cnt - 16'h0001;
				end
			end
			// Unused state code falls back to idle with the drive off
			default: begin
				s_d.state = OSF_IDLE;
			end
		endcase
		// Registered outputs
		s_d.drive = (s_d.state != OSF_IDLE);
		s_d.decel = (s_d.state == OSF_DECEL);
		s_d.lock  = dif.panel_lock;
		s_d.stop  = !dif.permit;
	end

	// State register with synchronous reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_q            <= '0;
			s_q.wait_r     <= 1'b1;
			s_q.pol        <= `OSF_POL_RST;
			s_q.opm        <= `OSF_OPM_RST;
			s_q.fsel       <= `OSF_FSEL_RST;
			s_q.decel_time <= `OSF_DECEL_RST;
			s_q.state      <= OSF_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Output ports
	assign avs_readdata_o    = s_q.rdata;
	assign avs_waitrequest_o = s_q.wait_r;
	assign drive_en_o        = s_q.drive;
	assign decel_o           = s_q.decel;
	assign coast_o           = s_q.coast;
	assign panel_lock_o      = s_q.lock;
	assign stop_active_o     = s_q.stop;
	assign pol_o             = s_q.pol;

	// Cycles a stop request has waited with the drive still on
	logic [31:0] lat_q;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !(!dif.permit && s_q.drive)) begin
			lat_q <= 32'h0000_0000;
		end else begin
			lat_q <= lat_q + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_running;
		s_q.state == OSF_RUN && s_q.run && dif.permit;
	endsequence
	sequence s_run_dropped;
		s_q.state == OSF_RUN && !s_q.run && dif.permit;
	endsequence

	property p_stop_cut;
		!dif.permit |=> !drive_en_o && s_q.state == OSF_IDLE;
	endproperty
	a_stop_cut: assert property (p_stop_cut) else $error("drive not cut on stop");

	property p_route;
		!dif.ext_asg |-> !dif.ext_in && !dif.term_stop;
	endproperty
	a_route: assert property (p_route) else $error("unassigned terminal routed");

	property p_resp;
		lat_q < RESP_MAX_CYC;
	endproperty
	a_resp: assert property (p_resp) else $error("stop response too slow");

	property p_interlock;
		(!dif.permit && s_q.run) [*3] |-> !drive_en_o;
	endproperty
	a_interlock: assert property (p_interlock) else $error("run honoured while stopped");

	property p_decel;
		s_run_dropped |=> decel_o && drive_en_o && !coast_o;
	endproperty
	a_decel: assert property (p_decel) else $error("run removal did not decelerate");

	property p_coast;
		s_running ##1 !dif.permit |=> coast_o && !drive_en_o && !decel_o;
	endproperty
	a_coast: assert property (p_coast) else $error("stop did not coast");

	property p_nc;
		(s_q.pol == 3'h2 || s_q.pol == 3'h3) && dif.ext_asg && !dif.ext_in
			&& s_q.opm != `OSF_OPM_LOCK |=> !drive_en_o;
	endproperty
	a_nc: assert property (p_nc) else $error("closed contact open but drive on");

	property p_split;
		(s_q.pol == 3'h4 || s_q.pol == 3'h5) && drive_en_o && s_q.opm != `OSF_OPM_LOCK
			&& dif.ext_asg |-> $past(dif.ext_in && !s_q.net);
	endproperty
	a_split: assert property (p_split) else $error("split polarity permit wrong");

	property p_as_lock;
		s_q.opm == `OSF_OPM_LOCK && dif.ext_asg && !dif.lock_asg
			|=> panel_lock_o == $past(dif.term_stop);
	endproperty
	a_as_lock: assert property (p_as_lock) else $error("stop input not used as lock");

	property p_lock_off;
		s_q.opm != `OSF_OPM_LOCK |=> !panel_lock_o;
	endproperty
	a_lock_off: assert property (p_lock_off) else $error("panel lock outside lock mode");

	property p_lock_no;
		s_q.opm == `OSF_OPM_LOCK && s_q.pol < 3'h2 && dif.ext_asg && dif.lock_asg
			|=> panel_lock_o == $past(dif.lock_in) && (!$past(dif.ext_in) || !drive_en_o);
	endproperty
	a_lock_no: assert property (p_lock_no) else $error("open-contact lock split wrong");

	property p_lock_nc;
		s_q.opm == `OSF_OPM_LOCK && s_q.pol >= 3'h2 && s_q.pol <= 3'h5 && dif.ext_asg
			&& !dif.ext_in |=> ($past(dif.lock_asg) ? !drive_en_o : panel_lock_o);
	endproperty
	a_lock_nc: assert property (p_lock_nc) else $error("closed-contact lock wrong");

	property p_any_mode;
		dif.term_stop && !(s_q.opm == `OSF_OPM_LOCK && !dif.lock_asg) |=> !drive_en_o;
	endproperty
	a_any_mode: assert property (p_any_mode) else $error("terminal stop ignored");

	property p_pol_rst;
		$past(sys_rst_i) |-> pol_o == 3'h0;
	endproperty
	a_pol_rst: assert property (@(posedge clk_i) p_pol_rst) else $error("polarity not 0");

	property p_both;
		drive_en_o && $past(s_q.pol) < 3'h2 |-> $past(!dif.term_stop && !s_q.net)
			or $past(s_q.opm == `OSF_OPM_LOCK);
	endproperty
	a_both: assert property (p_both) else $error("open-contact permit wrong");
endmodule // osf_top

/* tb/osf_sw_model.sv */
`timescale 1ns/1ps
module osf_sw_model (
	input  wire logic        clk_i,   // Bench clock
	input  wire logic [2:0]  close_i, // Closed contacts: stop, lock, spare
	output logic      [11:0] term_o   // Terminal levels
);
	// Contacts reach the terminals on the clock; an open contact reads low
	always_ff @(posedge clk_i) begin
		term_o <= {9'h000, close_i};
	end
endmodule // osf_sw_model

/* tb/tb.sv */
`timescale 1ns/1ps
`include "osf_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
	import osf_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  address = 5'h00;
	logic        rd_req = 1'b0;
	logic        wr_req = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] readdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        drive_en, decel, coast, panel_lock, stop_active;
	osf_pol_t    pol;
	logic [2:0]  sw = 3'h0;
	logic [11:0] term;
	logic        perm;
	int          errors = 0;
	int          checks_done = 0;

	// Free-running bench clock
	always #5 clk = ~clk;

	osf_sw_model i_sw (.clk_i(clk), .close_i(sw), .term_o(term));

	osf_top i_dut (.clk_i(clk), .sys_rst_i(rst), .term_i(term), .avs_address_i(address),
		.avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hF), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
		.drive_en_o(drive_en), .decel_o(decel), .coast_o(coast),
		.panel_lock_o(panel_lock), .stop_active_o(stop_active), .pol_o(pol));

	// Prints the verdict and ends the run
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		@(posedge clk);
		address <= a;
		rd_req <= !wr;
		wr_req <= wr;
		wdata <= wd;
		// Only the watchdog ends a wait that never completes
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		rdata = readdata;
		rd_req <= 1'b0;
		wr_req <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] ex);
		bus(1'b0, a, 32'h0000_0000);
		`CHK(nm, ex, rdata)
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic sw_set(input logic [2:0] v);
		@(posedge clk);
		sw <= v;
	endtask

	function automatic logic [31:0] ctrl(input logic [2:0] p, input logic [3:0] o,
		input logic n, input logic r);
		return {22'h00_0000, r, n, o, 1'b0, p};
	endfunction

	// Watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		stop_test();
	end

	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		rdc("ctrl", `OSF_ADDR_CTRL, 32'h0000_0000);
		`CHK("pol", 3'h0, pol)
		rdc("fsel1", `OSF_ADDR_FSEL1, 32'hFFFF_FFFF);
		rdc("decel_len", `OSF_ADDR_DECEL, 32'h0000_0064);
		bus(1'b1, 5'h18, 32'h1234_5678);
		rdc("unmapped", 5'h18, 32'h0000_0000);
		$display("test registers done");
		bus(1'b1, `OSF_ADDR_FSEL0, 32'hFFFF_FF18);
		bus(1'b1, `OSF_ADDR_DECEL, 32'h0000_0004);
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h0, 1'b0, 1'b1));
		wt(3);
		`CHK("drive", 1'b1, drive_en)
		sw_set(3'h1);
		wt(2);
		`CHK("drive", 1'b0, drive_en)
		`CHK("coast", 1'b1, coast)
		`CHK("stop", 1'b1, stop_active)
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h0, 1'b0, 1'b1));
		wt(3);
		`CHK("drive", 1'b0, drive_en)
		sw_set(3'h0);
		wt(3);
		`CHK("drive", 1'b1, drive_en)
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h0, 1'b0, 1'b0));
		wt(2);
		`CHK("decel", 1'b1, decel)
		`CHK("coast", 1'b0, coast)
		wt(6);
		`CHK("decel", 1'b0, decel)
		rdc("status", `OSF_ADDR_STATUS, 32'h0000_0000);
		$display("test stop and decel done");
		bus(1'b1, `OSF_ADDR_FSEL0, 32'hFFFF_FF17);
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h0, 1'b0, 1'b1));
		sw_set(3'h1);
		wt(3);
		`CHK("stop", 1'b0, stop_active)
		`CHK("drive", 1'b1, drive_en)
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h0, 1'b1, 1'b1));
		wt(2);
		`CHK("drive", 1'b0, drive_en)
		$display("test function code done");
		bus(1'b1, `OSF_ADDR_FSEL0, 32'hFFFF_FF18);
		for (int p = 0; p < 6; p++) begin
			for (int k = 0; k < 4; k++) begin
				perm = (p < 2) ? (k == 0) : (p < 4) ? (k == 3) : (k == 2);
				sw_set({2'b00, k[1]});
				bus(1'b1, `OSF_ADDR_CTRL, ctrl(p[2:0], 4'h0, k[0], 1'b1));
				wt(3);
				`CHK("stop", !perm, stop_active)
				`CHK("drive", perm, drive_en)
				`CHK("pol", p[2:0], pol)
			end
		end
		$display("test polarity done");
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h7, 1'b0, 1'b1));
		sw_set(3'h1);
		wt(3);
		`CHK("panel_lock", 1'b1, panel_lock)
		sw_set(3'h0);
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h2, 4'h7, 1'b0, 1'b1));
		wt(3);
		`CHK("panel_lock", 1'b1, panel_lock)
		bus(1'b1, `OSF_ADDR_FSEL0, 32'hFFFF_1918);
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h0, 4'h7, 1'b0, 1'b1));
		sw_set(3'h1);
		wt(3);
		`CHK("stop", 1'b1, stop_active)
		`CHK("panel_lock", 1'b0, panel_lock)
		sw_set(3'h2);
		wt(3);
		`CHK("panel_lock", 1'b1, panel_lock)
		`CHK("stop", 1'b0, stop_active)
		bus(1'b1, `OSF_ADDR_CTRL, ctrl(3'h2, 4'h7, 1'b0, 1'b1));
		sw_set(3'h0);
		wt(3);
		`CHK("stop", 1'b1, stop_active)
		$display("test panel interlock done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wt(1);
		`CHK("pol", 3'h0, pol)
		`CHK("stop", 1'b0, stop_active)
		rdc("ctrl", `OSF_ADDR_CTRL, 32'h0000_0000);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule // tb
